// ### pkg/afe_host_pkg.sv
// Purpose: shared constants for the imaging front end host link
// Assumes: one 250 MHz clock, both ends in one clock domain
// Notes:   register contents beyond format and setup are plain storage
//
// Contract
// - Output disable high floats every digital output
// - Strobe level at reset rise selects port
// - Serial transfer framed by high enable pulse
// - Parallel strobe active low; device acts then
// - Serial clock and data shift control bits
// - Select pin high data, low address
// - Read/write high drives upper byte, low releases
// - Clamp applied per pixel when select high
// - Line mode autocycle steps red, green, blue
// - Master clock integer multiple of pixel rate
// - Sample pulse per pixel aligns conversion
// - Pixel data 14-bit or 8/7/4 multiplexed
// - Three channels multiplexed; single channel selectable
// - Mux data on upper bits at 2x/4x
// - Read-back on upper byte or serial out
// - Reset returns control registers to defaults
package afe_host_pkg;
  // ----------------------------------------------------------------
  // Bus and register layout
  // ----------------------------------------------------------------
  localparam int         BUS_W          = 14;
  localparam int         CTL_LSB        = 6;
  localparam int         CTL_W          = 8;
  localparam int         NUM_REGS       = 8;
  localparam int         REG_IDX_W      = 3;
  localparam int         NUM_CHAN       = 3;
  localparam int         REG_FORMAT     = 0;
  localparam int         REG_SETUP      = 1;
  localparam int         FMT_LSB        = 0;
  localparam int         SETUP_LINE_BIT = 0;
  localparam int         SETUP_CHAN_LSB = 1;
  localparam int         ADDR_READ_BIT  = 7;
  localparam int         SER_BITS       = 16;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS         = 4;
  localparam int RESET_HOLD_NS  = 40;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int STB_NS         = 16;
  localparam int STB_CYC        = (STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCK_HALF_NS    = 8;
  localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int MCLK_HALF_NS   = 8;
  localparam int MCLK_HALF_CYC  = (MCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int MCLK_RATIO     = 6;
  // ----------------------------------------------------------------
  // Output formats
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {FMT_PAR14, FMT_MUX8, FMT_MUX7, FMT_MUX4} out_format_t;

  function automatic logic [1:0] last_beat(input out_format_t f);
    case (f)
      FMT_PAR14: last_beat = 2'd0;
      FMT_MUX4:  last_beat = 2'd3;
      default:   last_beat = 2'd1;
    endcase
  endfunction : last_beat
endpackage : afe_host_pkg

// ### pkg/afe_link_if.sv
// Purpose: pins between front end and scanner controller
// Assumes: bus level resolved here from the enables
// Notes:   undriven bus bits read low
`timescale 1ns/1ps
interface afe_link_if;
  logic        reset_active_low;
  logic        output_disable_n;
  logic        port_enable_or_strobe;
  logic        serial_in_or_data_addr_sel;
  logic        shift_clock_or_read_write;
  logic        master_clock;
  logic        pixel_sample_sync;
  logic        clamp_select_or_colour_autocycle;
  logic [13:0] dev_bus_out;
  logic [13:0] dev_bus_oe;
  logic [7:0]  ctl_bus_out;
  logic        ctl_bus_oe;
  logic        serial_readback_out;
  logic        serial_readback_oe;
  logic [13:0] pixel_bus;
  logic        serial_readback_level;

  assign pixel_bus[5:0]  = dev_bus_oe[5:0] & dev_bus_out[5:0];
  assign pixel_bus[13:6] = (dev_bus_oe[13:6] & dev_bus_out[13:6])
                         | ({8{ctl_bus_oe}} & ctl_bus_out);
  assign serial_readback_level = serial_readback_oe & serial_readback_out;

  modport device (
    input  reset_active_low, output_disable_n, port_enable_or_strobe,
    input  serial_in_or_data_addr_sel, shift_clock_or_read_write,
    input  master_clock, pixel_sample_sync, clamp_select_or_colour_autocycle,
    input  pixel_bus,
    output dev_bus_out, dev_bus_oe, serial_readback_out, serial_readback_oe
  );
  modport controller (
    output reset_active_low, output_disable_n, port_enable_or_strobe,
    output serial_in_or_data_addr_sel, shift_clock_or_read_write,
    output master_clock, pixel_sample_sync, clamp_select_or_colour_autocycle,
    output ctl_bus_out, ctl_bus_oe,
    input  pixel_bus, serial_readback_level
  );
endinterface : afe_link_if

// ### hdl/afe_device.sv
// Purpose: digital host side of a three channel imaging front end
// Assumes: link pins sampled on i_clock; converter results on i_conv_*
// Notes:   pixel beats advance on master clock rising edges
`timescale 1ns/1ps
module afe_device
  import afe_host_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [13:0] i_conv_red,
  input  wire logic [13:0] i_conv_green,
  input  wire logic [13:0] i_conv_blue,
  output logic             o_par_mode,
  output logic             o_line_mode,
  output logic [1:0]       o_channel,
  output logic             o_clamp_active,
  output logic [1:0]       o_format,
  output logic             o_pix_start,
  afe_link_if.device       lnk
);
  // ----------------------------------------------------------------
  // Pin edges
  // ----------------------------------------------------------------
  logic stb_q, sck_q, mclk_q, sync_q, acyc_q, lrst_q;
  wire  lrst_n    = lnk.reset_active_low;
  wire  stb       = lnk.port_enable_or_strobe;
  wire  sel_pin   = lnk.serial_in_or_data_addr_sel;
  wire  sclk_rw   = lnk.shift_clock_or_read_write;
  wire  mclk_rise = lnk.master_clock & ~mclk_q;
  wire  sync_rise = lnk.pixel_sample_sync & ~sync_q;
  wire  acyc_rise = lnk.clamp_select_or_colour_autocycle & ~acyc_q;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {stb_q, sck_q, mclk_q, sync_q, acyc_q, lrst_q} <= 6'h00;
    end else begin
      stb_q  <= stb;
      sck_q  <= sclk_rw;
      mclk_q <= lnk.master_clock;
      sync_q <= lnk.pixel_sample_sync;
      acyc_q <= lnk.clamp_select_or_colour_autocycle;
      lrst_q <= lrst_n;
    end
  end

  // ----------------------------------------------------------------
  // Port selection
  // ----------------------------------------------------------------
  logic par_mode_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      par_mode_r <= 1'b0;
    end else if (lrst_n && !lrst_q) begin
      par_mode_r <= stb;
    end
  end

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic [15:0] ser_sh_r;
  logic [4:0]  ser_cnt_r;
  logic [7:0]  rbk_sh_r;
  logic [7:0]  regs_r [NUM_REGS];
  wire         ser_en   = ~par_mode_r & stb & lrst_n;
  wire         ser_rise = ser_en & sclk_rw & ~sck_q;
  wire         ser_end  = ~par_mode_r & ~stb & stb_q;
  wire         ser_wr   = ser_end && ser_cnt_r == 5'(SER_BITS) && !ser_sh_r[15];
  wire [2:0]   ser_ridx = {ser_sh_r[1:0], sel_pin};

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ser_sh_r  <= 16'h0000;
      ser_cnt_r <= 5'h00;
      rbk_sh_r  <= 8'h00;
    end else if (!ser_en) begin
      ser_cnt_r <= 5'h00;
    end else if (ser_rise) begin
      ser_sh_r <= {ser_sh_r[14:0], sel_pin};
      if (ser_cnt_r != 5'(SER_BITS)) begin
        ser_cnt_r <= ser_cnt_r + 5'h01;
      end
      if (ser_cnt_r == 5'h07 && ser_sh_r[6]) begin
        rbk_sh_r <= regs_r[ser_ridx];
      end else if (ser_cnt_r >= 5'h08) begin
        rbk_sh_r <= {rbk_sh_r[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Parallel port
  // ----------------------------------------------------------------
  logic [2:0] addr_r;
  wire        par_fall = par_mode_r & lrst_n & ~stb & stb_q;
  wire [7:0]  bus_byte = lnk.pixel_bus[13:6];
  wire        par_wr   = par_fall & sel_pin & ~sclk_rw;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= 3'h0;
    end else if (!lrst_n) begin
      addr_r <= 3'h0;
    end else if (par_fall && !sel_pin) begin
      addr_r <= bus_byte[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire       wr_en  = par_wr | ser_wr;
  wire [2:0] wr_idx = par_wr ? addr_r : ser_sh_r[10:8];
  wire [7:0] wr_dat = par_wr ? bus_byte : ser_sh_r[7:0];

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (!lrst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (wr_en) begin
      regs_r[wr_idx] <= wr_dat;
    end
  end

  wire out_format_t fmt       = out_format_t'(regs_r[REG_FORMAT][FMT_LSB +: 2]);
  wire              line_mode = regs_r[REG_SETUP][SETUP_LINE_BIT];
  wire [1:0]        base_ch   = regs_r[REG_SETUP][SETUP_CHAN_LSB +: 2];

  // ----------------------------------------------------------------
  // Channel and clamp
  // ----------------------------------------------------------------
  logic [1:0] chan_r;
  logic       clamp_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_r  <= 2'h0;
      clamp_r <= 1'b0;
    end else if (!line_mode) begin
      chan_r <= base_ch;
      if (sync_rise) begin
        clamp_r <= lnk.clamp_select_or_colour_autocycle;
      end
    end else begin
      clamp_r <= 1'b0;
      if (acyc_rise) begin
        chan_r <= (chan_r >= 2'(NUM_CHAN - 1)) ? 2'h0 : chan_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel stream
  // ----------------------------------------------------------------
  logic [13:0] word_r [NUM_CHAN];
  logic [1:0]  wi_r, bi_r, nlast_r;
  logic        active_r;
  logic [13:0] out_r;
  wire  [13:0] cur   = word_r[wi_r];
  wire  [15:0] ext4  = {cur, 2'b00};
  wire  [3:0]  nib   = ext4[15 - 4 * bi_r -: 4];
  wire  [13:0] sel_1 = (chan_r == 2'h1) ? i_conv_green :
                       (chan_r == 2'h2) ? i_conv_blue : i_conv_red;
  logic [13:0] piece;

  always_comb begin
    case (fmt)
      FMT_PAR14: piece = cur;
      FMT_MUX8:  piece = bi_r[0] ? {cur[5:0], 8'h00} : {cur[13:6], 6'h00};
      FMT_MUX7:  piece = bi_r[0] ? {cur[6:0], 7'h00} : {cur[13:7], 7'h00};
      FMT_MUX4:  piece = {nib, 10'h000};
      default:   piece = cur;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        word_r[i] <= 14'h0000;
      end
      {wi_r, bi_r, nlast_r} <= 6'h00;
      active_r              <= 1'b0;
      out_r                 <= 14'h0000;
    end else if (sync_rise) begin
      if (mclk_rise && active_r) begin
        out_r <= piece; // Beat still pending from the previous pixel shares this edge
      end
      word_r[0] <= line_mode ? sel_1 : i_conv_red;
      word_r[1] <= i_conv_green;
      word_r[2] <= i_conv_blue;
      nlast_r   <= line_mode ? 2'h0 : 2'(NUM_CHAN - 1);
      {wi_r, bi_r} <= 4'h0;
      active_r  <= 1'b1;
    end else if (mclk_rise && active_r) begin
      out_r <= piece;
      if (bi_r == last_beat(fmt)) begin
        bi_r <= 2'h0;
        if (wi_r == nlast_r) begin
          active_r <= 1'b0;
        end else begin
          wi_r <= wi_r + 2'h1;
        end
      end else begin
        bi_r <= bi_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Upper byte is released whenever read/write is low, even between
  // strobes, so the controller may set its byte up early.
  wire dis    = lnk.output_disable_n;
  wire rd_par = par_mode_r & ~stb & sclk_rw;
  wire up_rel = par_mode_r & ~sclk_rw;

  assign lnk.dev_bus_out = rd_par ? {regs_r[addr_r], 6'h00} : out_r;
  assign lnk.dev_bus_oe  = dis ? 14'h0000 :
                           up_rel ? 14'h003F : 14'h3FFF;
  assign lnk.serial_readback_out = rbk_sh_r[7];
  assign lnk.serial_readback_oe  = ~dis & ~par_mode_r;

  assign o_par_mode     = par_mode_r;
  assign o_line_mode    = line_mode;
  assign o_channel      = chan_r;
  assign o_clamp_active = clamp_r;
  assign o_format       = fmt;
  assign o_pix_start    = sync_rise;
endmodule : afe_device

// ### hdl/afe_controller.sv
// Purpose: scanner controller end of the front end link
// Assumes: one request at a time, taken while o_ready is high
// Notes:   master clock and sample pulse from a fixed divider
`timescale 1ns/1ps
module afe_controller
  import afe_host_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_par_mode,
  input  wire logic        i_out_disable,
  input  wire logic        i_clamp_or_cycle,
  input  wire logic        i_req,
  input  wire logic        i_req_read,
  input  wire logic [2:0]  i_req_idx,
  input  wire logic [7:0]  i_req_data,
  output logic             o_ready,
  output logic [7:0]       o_rd_data,
  output logic             o_rd_valid,
  output logic [13:0]      o_bus_word,
  output logic             o_bus_valid,
  afe_link_if.controller   lnk
);
  typedef enum logic [2:0] {
    ST_RESET, ST_IDLE, ST_P_SETUP, ST_P_STROBE, ST_P_GAP, ST_S_LOW, ST_S_HIGH
  } state_t;
  state_t      st_r;
  logic [4:0]  tcnt_r, bit_r;
  logic        par_r, phase_r, read_r;
  logic        rst_r, stb_r, sel_r, sck_r, ctl_oe_r;
  logic [7:0]  ctl_r;
  logic [15:0] sh_r;
  logic [7:0]  rd_r;

  // ----------------------------------------------------------------
  // Master clock and sample pulse
  // ----------------------------------------------------------------
  logic [3:0] mdiv_r, mcnt_r;
  logic       mclk_r, sync_r;
  wire        mtick = (mdiv_r == 4'(MCLK_HALF_CYC - 1));
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      {mdiv_r, mcnt_r, mclk_r, sync_r} <= 10'h000;
    end else begin
      mdiv_r <= mtick ? 4'h0 : mdiv_r + 4'h1;
      if (mtick) begin
        mclk_r <= ~mclk_r;
        if (!mclk_r) begin
          mcnt_r <= (mcnt_r == 4'(MCLK_RATIO - 1)) ? 4'h0 : mcnt_r + 4'h1;
          sync_r <= (mcnt_r == 4'(MCLK_RATIO - 1));
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  wire take = i_req & o_ready;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= ST_RESET;
      {tcnt_r, bit_r} <= 10'h000;
      {par_r, phase_r, read_r, rst_r, stb_r, sel_r, sck_r, ctl_oe_r} <= 8'h00;
      {ctl_r, rd_r, o_rd_data} <= 24'h000000;
      sh_r <= 16'h0000;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      case (st_r)
        ST_RESET: begin
          par_r  <= i_par_mode;
          stb_r  <= i_par_mode;
          sck_r  <= i_par_mode;
          tcnt_r <= tcnt_r + 5'h01;
          if (tcnt_r == 5'(RESET_HOLD_CYC - 1)) begin
            rst_r <= 1'b1;
            st_r  <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (take) begin
            read_r  <= i_req_read;
            phase_r <= 1'b0;
            tcnt_r  <= 5'h00;
            bit_r   <= 5'h00;
            sh_r    <= {i_req_read, 4'h0, i_req_idx, i_req_data};
            ctl_r   <= {5'h00, i_req_idx};
            st_r    <= par_r ? ST_P_SETUP : ST_S_LOW;
            if (!par_r) begin
              stb_r <= 1'b1;
            end
          end
        end
        ST_P_SETUP: begin
          sel_r    <= phase_r;
          sck_r    <= phase_r & read_r;
          ctl_oe_r <= ~(phase_r & read_r);
          st_r     <= ST_P_STROBE;
        end
        ST_P_STROBE: begin
          stb_r  <= 1'b0;
          tcnt_r <= tcnt_r + 5'h01;
          if (tcnt_r == 5'(STB_CYC)) begin
            stb_r <= 1'b1;
            if (phase_r && read_r) begin
              o_rd_data <= lnk.pixel_bus[13:6];
            end
            st_r <= ST_P_GAP;
          end
        end
        ST_P_GAP: begin
          sck_r    <= 1'b1;
          ctl_oe_r <= 1'b0;
          tcnt_r   <= 5'h00;
          phase_r  <= 1'b1;
          ctl_r    <= sh_r[7:0];
          if (phase_r) begin
            o_rd_valid <= read_r;
            st_r       <= ST_IDLE;
          end else begin
            st_r <= ST_P_SETUP;
          end
        end
        ST_S_LOW: begin
          sck_r  <= 1'b0;
          sel_r  <= sh_r[15];
          tcnt_r <= tcnt_r + 5'h01;
          if (tcnt_r == 5'(SCK_HALF_CYC)) begin
            tcnt_r <= 5'h00;
            if (bit_r >= 5'h08) begin
              rd_r <= {rd_r[6:0], lnk.serial_readback_level};
            end
            st_r <= ST_S_HIGH;
          end
        end
        ST_S_HIGH: begin
          sck_r  <= 1'b1;
          tcnt_r <= tcnt_r + 5'h01;
          if (tcnt_r == 5'(SCK_HALF_CYC)) begin
            tcnt_r <= 5'h00;
            sck_r  <= 1'b0;
            sh_r   <= {sh_r[14:0], 1'b0};
            bit_r  <= bit_r + 5'h01;
            if (bit_r == 5'(SER_BITS - 1)) begin
              stb_r      <= 1'b0;
              o_rd_data  <= rd_r;
              o_rd_valid <= read_r;
              st_r       <= ST_IDLE;
            end else begin
              st_r <= ST_S_LOW;
            end
          end
        end
        default: st_r <= ST_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel capture
  // ----------------------------------------------------------------
  logic mclk_q;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      mclk_q      <= 1'b0;
      o_bus_word  <= 14'h0000;
      o_bus_valid <= 1'b0;
    end else begin
      mclk_q      <= mclk_r;
      o_bus_valid <= ~mclk_r & mclk_q;
      if (!mclk_r && mclk_q) begin
        o_bus_word <= lnk.pixel_bus;
      end
    end
  end

  assign o_ready = (st_r == ST_IDLE);
  assign lnk.reset_active_low                 = rst_r;
  assign lnk.output_disable_n                 = i_out_disable;
  assign lnk.port_enable_or_strobe            = stb_r;
  assign lnk.serial_in_or_data_addr_sel       = sel_r;
  assign lnk.shift_clock_or_read_write        = sck_r;
  assign lnk.master_clock                     = mclk_r;
  assign lnk.pixel_sample_sync                = sync_r;
  assign lnk.clamp_select_or_colour_autocycle = i_clamp_or_cycle;
  assign lnk.ctl_bus_out                      = ctl_r;
  assign lnk.ctl_bus_oe                       = ctl_oe_r;
endmodule : afe_controller

// ### tb/afe_link_properties.sv
// Purpose: link assertions for the front end host pins
// Assumes: one clock domain, i_nrst async low
// Notes:   port mode mirrored from the strap at link reset rise
`timescale 1ns/1ps
module afe_link_properties (
  input wire logic        i_clock,
  input wire logic        i_nrst,
  input wire logic        reset_active_low,
  input wire logic        output_disable_n,
  input wire logic        port_enable_or_strobe,
  input wire logic        shift_clock_or_read_write,
  input wire logic        master_clock,
  input wire logic        pixel_sample_sync,
  input wire logic [13:0] dev_bus_oe,
  input wire logic        ctl_bus_oe,
  input wire logic        serial_readback_oe
);
  // ------------------------------------------------------------
  // Strap mirror
  // ------------------------------------------------------------
  logic par_r;
  logic rst_d_r;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      par_r   <= 1'b0;
      rst_d_r <= 1'b0;
    end else begin
      rst_d_r <= reset_active_low;
      if (reset_active_low && !rst_d_r) par_r <= port_enable_or_strobe;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_par_read;
    par_r && !port_enable_or_strobe && shift_clock_or_read_write && !output_disable_n;
  endsequence
  sequence s_ctl_drive;
    ctl_bus_oe ##1 ctl_bus_oe;
  endsequence
  a_disable_floats: assert property (
    output_disable_n ##1 output_disable_n |-> dev_bus_oe == 14'h0000 && !serial_readback_oe)
    else $error("outputs driven while disabled");
  a_write_releases: assert property (
    s_ctl_drive |-> dev_bus_oe[13:6] == 8'h00) else $error("bus contention on write");
  a_read_drives: assert property (
    s_par_read ##1 s_par_read |-> dev_bus_oe[13:6] == 8'hFF) else $error("read byte not driven");
  a_strobe_width: assert property (
    par_r && $fell(port_enable_or_strobe)
    |-> !port_enable_or_strobe[*3] ##[1:6] port_enable_or_strobe) else $error("strobe width");
  a_strap_steady: assert property (
    $rose(reset_active_low) |-> $stable(port_enable_or_strobe)) else $error("strap moved");
  a_mclk_period: assert property (
    $rose(master_clock) |=> master_clock ##1 !master_clock[*2] ##1 master_clock)
    else $error("master clock period");
  a_sync_spacing: assert property (
    $rose(pixel_sample_sync) |-> pixel_sample_sync[*4] ##21 $rose(pixel_sample_sync))
    else $error("sample sync spacing");
  a_readback_serial_only: assert property (
    par_r |-> !serial_readback_oe) else $error("serial out in parallel mode");
endmodule : afe_link_properties

// ### tb/tb_imaging_afe_host_interface.sv
// Purpose: both ends joined; registers, pixels, disable, autocycle
// Assumes: 4 ns clock, fixed seed
// Notes:   read data expectations queued by the driver
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_imaging_afe_host_interface;
  import afe_host_pkg::*;
  logic        i_clock = 0, i_nrst = 0, par_mode = 0, out_dis = 0, clamp = 0;
  logic        req = 0, req_rd = 0;
  logic [2:0]  req_idx = 0;
  logic [7:0]  req_data = 0, d, e;
  logic [13:0] conv [3];
  logic [7:0]  expq[$];
  wire         ready, rd_valid, bus_valid, par_o, line_o, clamp_o, pix_start;
  wire [7:0]   rd_data;
  wire [13:0]  bus_word;
  wire [1:0]   fmt_o, chan_o;
  int          failures = 0, total_checks = 0, cyc = 0, k;
  always #2 i_clock = ~i_clock;
  afe_link_if lnk ();
  afe_device u_afe_device (.i_clock, .i_nrst, .i_conv_red(conv[0]), .i_conv_green(conv[1]),
    .i_conv_blue(conv[2]), .o_par_mode(par_o), .o_line_mode(line_o), .o_channel(chan_o),
    .o_clamp_active(clamp_o), .o_format(fmt_o), .o_pix_start(pix_start), .lnk(lnk));
  afe_controller u_afe_controller (.i_clock, .i_nrst, .i_par_mode(par_mode),
    .i_out_disable(out_dis), .i_clamp_or_cycle(clamp), .i_req(req), .i_req_read(req_rd),
    .i_req_idx(req_idx), .i_req_data(req_data), .o_ready(ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_bus_word(bus_word), .o_bus_valid(bus_valid), .lnk(lnk));
  afe_link_properties u_afe_link_properties (.i_clock, .i_nrst,
    .reset_active_low(lnk.reset_active_low), .output_disable_n(lnk.output_disable_n),
    .port_enable_or_strobe(lnk.port_enable_or_strobe), .master_clock(lnk.master_clock),
    .shift_clock_or_read_write(lnk.shift_clock_or_read_write), .ctl_bus_oe(lnk.ctl_bus_oe),
    .pixel_sample_sync(lnk.pixel_sample_sync), .dev_bus_oe(lnk.dev_bus_oe),
    .serial_readback_oe(lnk.serial_readback_oe));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic xfer(logic r, logic [2:0] i, logic [7:0] v);
    k = 0;
    while (ready !== 1'b1 && k < 400) begin tick(1); k++; end
    if (k == 400) failures++;
    req = 1;
    req_rd = r;
    req_idx = i;
    req_data = v;
    tick(1);
    req = 0;
  endtask : xfer
  task automatic beats(int n);
    k = 0;
    while (n > 0 && k < 2000) begin tick(1); k++; if (bus_valid === 1'b1) n--; end
    if (n > 0) failures++;
  endtask : beats
  // Align to a pixel start; the first capture after it is the old tail
  task automatic to_pixel();
    k = 0;
    while (pix_start !== 1'b1 && k < 100) begin tick(1); k++; end
    `CHK("sync", 1'b1, pix_start)
    beats(1);
  endtask : to_pixel
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // Read-back monitor and watchdog
  // ------------------------------------------------------------
  always @(negedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end else if (rd_valid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : ~rd_data;
      `CHK("readback", e, rd_data)
    end
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hCEDE));
    foreach (conv[c]) conv[c] = 14'($urandom);
    for (int m = 0; m < 2; m++) begin
      i_nrst = 0;
      par_mode = m[0];
      tick(3);
      i_nrst = 1;
      k = 0;
      while (lnk.reset_active_low !== 1'b1 && k < 40) begin tick(1); k++; end
      `CHK("strap", m[0], lnk.port_enable_or_strobe)
      tick(2);
      `CHK("mode", m[0], par_o)
      `CHK("format reset", 2'h0, fmt_o)
      for (int i = 0; i < 8; i++) begin
        d = 8'($urandom);
        xfer(0, i[2:0], d);
        expq.push_back(d);
        xfer(1, i[2:0], 8'h00);
        if (i == 0) `CHK("format", d[1:0], fmt_o)
        if (i == 1) `CHK("line", d[0], line_o)
      end
      k = 0;
      while (expq.size() != 0 && k < 400) begin tick(1); k++; end
      $display("test registers mode %0d done", m);
    end
    xfer(0, 3'h0, 8'h00);
    xfer(0, 3'h1, 8'h00);
    beats(8);
    to_pixel();
    for (int c = 0; c < 3; c++) begin beats(1); `CHK("pixel", conv[c], bus_word) end
    xfer(0, 3'h0, 8'h01);
    beats(4);
    to_pixel();
    beats(1);
    `CHK("mux8 high", conv[0] & 14'h3FC0, bus_word)
    beats(1);
    `CHK("mux8 low", 14'(conv[0] << 8), bus_word)
    out_dis = 1;
    beats(2);
    `CHK("disabled word", 14'h0000, bus_word)
    `CHK("disabled bus", 14'h0000, lnk.pixel_bus)
    out_dis = 0;
    clamp = 1;
    k = 0;
    while (clamp_o !== 1'b1 && k < 500) begin tick(1); k++; end
    `CHK("clamp", 1'b1, clamp_o)
    xfer(0, 3'h1, 8'h01);
    k = 0;
    while (line_o !== 1'b1 && k < 100) begin tick(1); k++; end
    clamp = 0;
    tick(1);
    clamp = 1;
    k = 0;
    while (chan_o !== 2'h1 && k < 500) begin tick(1); k++; end
    `CHK("autocycle", 2'h1, chan_o)
    $display("test pixels done");
    tick(300);
    `CHK("queue", 0, expq.size())
    finish_test();
  end
endmodule : tb_imaging_afe_host_interface
